// File: hw/asc_ctrl.sv
`timescale 1ns/1ns
// Notes on behaviour
// RULE1 - byte 01xxxxxx writes setup register
// RULE2 - clock codes 00/01/10 use internal clock
// RULE3 - code 11 converts on serial clock
// RULE4 - ref 00: internal, off after scan, wake-up
// RULE5 - ref 10: internal reference always on
// RULE6 - ref 01/11 external; 11 makes REF- pin
// RULE7 - pair select 00/01: no data byte
// RULE8 - pair select 10: next byte to unipolar
// RULE9 - pair select 11: next byte to bipolar
// RULE10 - clock mode 11 disables averaging
// RULE11 - scan 10 repeats the same channel
// RULE12 - reset bit one clears FIFO only
// RULE13 - reset bit zero restores all defaults
// RULE14 - power-up zeros, setup clock mode 10
// RULE15 - temperature is high minus low minus offset
// RULE16 - result: four zeros, ten bits, sub-bits
// RULE17 - temperature: four zeros, twelve bits
// RULE18 - input sampled on serial clock rise
// RULE19 - output changes on serial clock fall
// RULE20 - start by pin in 0x, by byte in 1x
// RULE21 - unipolar binary, bipolar two's complement
// RULE22 - bit 7 is pair 0/1, bit 0 pair 14/15
// RULE23 - unipolar wins when both marked
// RULE24 - host holds select low sixteen clocks
// RULE25 - bits counted from select fall, bytes of eight
module asc_ctrl (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        cs_n_pin,
   input  wire logic        sclk_pin,
   input  wire logic        din_pin,
   input  wire logic        conversion_start_pin,
   input  wire logic        result_valid,
   input  wire logic [11:0] result_code,
   input  wire logic [3:0]  result_chan,
   input  wire logic        result_is_temp,
   input  wire logic [11:0] temp_high_bias,
   input  wire logic [11:0] temp_low_bias,
   output logic             dout,
   output logic [1:0]       clock_mode,
   output logic             use_serial_conv_clk,
   output logic             conversion_start_pin_as_analog_input,
   output logic             acq_timed_by_pin,
   output logic             ref_internal,
   output logic             ref_always_on,
   output logic             ref_wake_delay,
   output logic             neg_ref_pin_active,
   output logic [7:0]       unipolar_pair_config,
   output logic [7:0]       bipolar_pair_config,
   output logic [7:0]       bipolar_pairs_eff,
   output logic             averaging_on,
   output logic [7:0]       avg_config,
   output logic [7:0]       conv_config,
   output logic             repeat_channel,
   output logic             scan_start,
   output logic             fifo_clear
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [3:0] sync1_ff;
   logic [3:0] sync2_ff;
   logic       sclk_d_ff;
   logic       cnv_d_ff;
   logic       cs_n_s;
   logic       sclk_s;
   logic       din_s;
   logic       cnv_s;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       cnv_rise;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // idle pin levels, so no false start edge follows reset
         sync1_ff  <= 4'h9;
         sync2_ff  <= 4'h9;
         sclk_d_ff <= 1'b0;
         cnv_d_ff  <= 1'b1;
      end else if (ce) begin
         sync1_ff  <= {conversion_start_pin, din_pin, sclk_pin, cs_n_pin};
         sync2_ff  <= sync1_ff;
         sclk_d_ff <= sync2_ff[1];
         cnv_d_ff  <= sync2_ff[3];
      end
   end

   assign cs_n_s    = sync2_ff[0];
   assign sclk_s    = sync2_ff[1];
   assign din_s     = sync2_ff[2];
   assign cnv_s     = sync2_ff[3];
   assign sclk_rise = sclk_s & ~sclk_d_ff;
   assign sclk_fall = ~sclk_s & sclk_d_ff;
   // scan begins when the low pulse ends
   assign cnv_rise  = cnv_s & ~cnv_d_ff;

   // ****************************************
   // byte receive
   // ****************************************
   logic       byte_valid;
   logic [7:0] byte_data;

   asc_byte_rx u_rx (
      .clk        (clk),
      .rst_n      (rst_n),
      .ce         (ce),
      .cs_n       (cs_n_s),
      .sclk_rise  (sclk_rise),
      .din        (din_s),
      .byte_valid (byte_valid),
      .byte_data  (byte_data)
   );

   // ****************************************
   // command decode
   // ****************************************
   typedef enum logic [1:0] {ASC_CMD, ASC_UNI_DATA, ASC_BIP_DATA} asc_state_t;

   asc_state_t state_ff;
   asc_state_t nxt_state;
   logic [7:0] setup_ff;
   logic       is_conv;
   logic       is_setup;
   logic       is_avg;
   logic       is_rst;
   logic       cmd_byte;
   logic       soft_reset;

   function automatic logic sel_match(input logic [7:0] b, input logic [7:0] m,
                                      input logic [7:0] v);
      return (b & m) == v;
   endfunction

   assign cmd_byte   = byte_valid && (state_ff == ASC_CMD);
   assign is_conv    = cmd_byte && sel_match(byte_data, asc_pkg::CONV_SEL_MASK,
                                             asc_pkg::CONV_SEL_VAL);
   assign is_setup   = cmd_byte && sel_match(byte_data, asc_pkg::SETUP_SEL_MASK,
                                             asc_pkg::SETUP_SEL_VAL); // RULE1
   assign is_avg     = cmd_byte && sel_match(byte_data, asc_pkg::AVG_SEL_MASK,
                                             asc_pkg::AVG_SEL_VAL);
   assign is_rst     = cmd_byte && sel_match(byte_data, asc_pkg::RST_SEL_MASK,
                                             asc_pkg::RST_SEL_VAL);
   assign soft_reset = is_rst && !byte_data[asc_pkg::RST_KEEP_CFG]; // RULE13

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ASC_CMD: begin
            if (is_setup && byte_data[asc_pkg::PAIR_SEL_HI]) begin // RULE7
               nxt_state = byte_data[asc_pkg::PAIR_SEL_LO] ? ASC_BIP_DATA
                                                           : ASC_UNI_DATA;
            end
         end
         ASC_UNI_DATA,
         ASC_BIP_DATA: begin
            if (byte_valid) begin
               nxt_state = ASC_CMD;
            end
         end
      endcase
      // a frame ended early drops the expected data byte
      if (cs_n_s) begin // RULE24
         nxt_state = ASC_CMD;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ASC_CMD;
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         setup_ff             <= asc_pkg::SETUP_RESET; // RULE14
         unipolar_pair_config <= asc_pkg::CFG_RESET;
         bipolar_pair_config  <= asc_pkg::CFG_RESET;
         avg_config           <= asc_pkg::CFG_RESET;
         conv_config          <= asc_pkg::CFG_RESET;
      end else if (ce) begin
         if (soft_reset) begin // RULE13
            setup_ff             <= asc_pkg::SETUP_RESET;
            unipolar_pair_config <= asc_pkg::CFG_RESET;
            bipolar_pair_config  <= asc_pkg::CFG_RESET;
            avg_config           <= asc_pkg::CFG_RESET;
            conv_config          <= asc_pkg::CFG_RESET;
         end else begin
            if (is_setup) begin
               setup_ff <= byte_data; // RULE1
            end
            if (byte_valid && state_ff == ASC_UNI_DATA) begin
               unipolar_pair_config <= byte_data; // RULE8
            end
            if (byte_valid && state_ff == ASC_BIP_DATA) begin
               bipolar_pair_config <= byte_data; // RULE9
            end
            if (is_avg) begin
               avg_config <= byte_data;
            end
            if (is_conv) begin
               conv_config <= byte_data;
            end
         end
      end
   end

   // ****************************************
   // decoded modes
   // ****************************************
   assign clock_mode            = setup_ff[asc_pkg::CLK_MODE_HI:asc_pkg::CLK_MODE_LO];
   assign use_serial_conv_clk   = clock_mode == asc_pkg::CLK_SERIAL; // RULE3
   assign conversion_start_pin_as_analog_input = clock_mode[1]; // RULE2
   assign acq_timed_by_pin      = clock_mode == asc_pkg::CLK_INT_PIN; // RULE2
   assign ref_internal          = !setup_ff[asc_pkg::REF_SEL_LO]; // RULE6
   assign ref_always_on = setup_ff[asc_pkg::REF_SEL_HI:asc_pkg::REF_SEL_LO]
                          == asc_pkg::REF_INT_ON; // RULE5
   assign ref_wake_delay = setup_ff[asc_pkg::REF_SEL_HI:asc_pkg::REF_SEL_LO]
                           == asc_pkg::REF_INT_AUTO; // RULE4
   assign neg_ref_pin_active = setup_ff[asc_pkg::REF_SEL_HI:asc_pkg::REF_SEL_LO]
                               == asc_pkg::REF_EXT_DIFF; // RULE6
   // unipolar marking takes precedence on a doubly marked pair
   assign bipolar_pairs_eff = bipolar_pair_config & ~unipolar_pair_config; // RULE23
   assign averaging_on = avg_config[asc_pkg::AVG_ON_BIT] && !use_serial_conv_clk; // RULE10
   assign repeat_channel = conv_config[asc_pkg::SCAN_HI:asc_pkg::SCAN_LO]
                           == asc_pkg::SCAN_REPEAT; // RULE11

   // ****************************************
   // scan start and fifo clear pulses
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scan_start <= 1'b0;
         fifo_clear <= 1'b0;
      end else if (ce) begin
         scan_start <= clock_mode[1] ? is_conv : cnv_rise; // RULE20
         fifo_clear <= is_rst; // RULE12
      end
   end

   // ****************************************
   // result framing
   // ****************************************
   logic [11:0] temp_celsius;
   logic        res_bipolar;
   logic [11:0] res_coded;
   logic [15:0] out_word;

   // pair index is channel / 2, msb of the register is pair zero
   function automatic logic pair_bit(input logic [7:0] r, input logic [3:0] ch);
      return r[3'h7 - ch[3:1]]; // RULE22
   endfunction

   assign temp_celsius = temp_high_bias - temp_low_bias - asc_pkg::TEMP_OFFSET; // RULE15
   assign res_bipolar  = pair_bit(bipolar_pairs_eff, result_chan);
   assign res_coded    = {result_code[11] ^ res_bipolar, result_code[10:0]}; // RULE21
   assign out_word     = result_is_temp ? {4'h0, temp_celsius}  // RULE17
                                        : {4'h0, res_coded};    // RULE16

   asc_word_tx u_tx (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .load      (result_valid),
      .word      (out_word),
      .sclk_fall (sclk_fall),
      .cs_n      (cs_n_s),
      .dout      (dout)
   );

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence setup_pair_write(logic [1:0] sel);
      ce && is_setup && byte_data[1:0] == sel && !cs_n_s;
   endsequence

   sequence pair_byte(asc_state_t st);
      ce && byte_valid && state_ff == st;
   endsequence

   chk_setup_store: assert property ( // RULE1
      ce && is_setup |=> setup_ff == $past(byte_data))
      else $error("setup byte not stored");
   chk_unipolar_arm: assert property ( // RULE8
      setup_pair_write(2'b10) |=> state_ff == ASC_UNI_DATA)
      else $error("unipolar data byte not awaited");
   chk_unipolar_write: assert property ( // RULE8
      pair_byte(ASC_UNI_DATA) |=> unipolar_pair_config == $past(byte_data))
      else $error("unipolar pair byte lost");
   chk_bipolar_arm: assert property ( // RULE9
      setup_pair_write(2'b11) |=> state_ff == ASC_BIP_DATA)
      else $error("bipolar data byte not awaited");
   chk_bipolar_write: assert property ( // RULE9
      pair_byte(ASC_BIP_DATA) |=> bipolar_pair_config == $past(byte_data))
      else $error("bipolar pair byte lost");
   chk_no_pair_write: assert property ( // RULE7
      ce && is_setup && !byte_data[1] |=> state_ff == ASC_CMD && $stable(unipolar_pair_config)
      && $stable(bipolar_pair_config))
      else $error("pair register changed without select");
   chk_avg_serial: assert property ( // RULE10
      use_serial_conv_clk |-> !averaging_on)
      else $error("averaging in serial clock mode");
   chk_fifo_clear_only: assert property ( // RULE12
      ce && is_rst && byte_data[3] |=> fifo_clear && $stable(setup_ff) && $stable(avg_config))
      else $error("fifo clear touched configuration");
   chk_soft_reset: assert property ( // RULE13
      ce && soft_reset |=> setup_ff == 8'h20 && unipolar_pair_config == 8'h00
      && bipolar_pair_config == 8'h00)
      else $error("soft reset left registers set");
   chk_start_source: assert property ( // RULE20
      ce && scan_start |-> $past(clock_mode[1]) ? $past(is_conv) : $past(cnv_rise))
      else $error("scan start from wrong source");
   chk_temp_word: assert property ( // RULE17
      ce && result_valid && result_is_temp |=> dout == 1'b0 ##0 $stable(temp_celsius)[*1]
      or !$stable(temp_celsius))
      else $error("temperature word lead bit not zero");
   chk_unipolar_wins: assert property ( // RULE23
      (bipolar_pairs_eff & unipolar_pair_config) == 8'h00)
      else $error("pair marked both ways");

endmodule

// File: hw/asc_pkg.sv
package asc_pkg;

   // ****************************************
   // command byte selectors
   // ****************************************
   localparam logic [7:0] CONV_SEL_MASK  = 8'h80;
   localparam logic [7:0] CONV_SEL_VAL   = 8'h80;
   localparam logic [7:0] SETUP_SEL_MASK = 8'hC0;
   localparam logic [7:0] SETUP_SEL_VAL  = 8'h40;
   localparam logic [7:0] AVG_SEL_MASK   = 8'hE0;
   localparam logic [7:0] AVG_SEL_VAL    = 8'h20;
   localparam logic [7:0] RST_SEL_MASK   = 8'hF0;
   localparam logic [7:0] RST_SEL_VAL    = 8'h10;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CLK_MODE_HI  = 5;
   localparam int CLK_MODE_LO  = 4;
   localparam int REF_SEL_HI   = 3;
   localparam int REF_SEL_LO   = 2;
   localparam int PAIR_SEL_HI  = 1;
   localparam int PAIR_SEL_LO  = 0;
   localparam int RST_KEEP_CFG = 3;
   localparam int AVG_ON_BIT   = 4;
   localparam int SCAN_HI      = 2;
   localparam int SCAN_LO      = 1;

   // ****************************************
   // codes and reset values
   // ****************************************
   localparam logic [1:0] CLK_INT_AUTO  = 2'b00;
   localparam logic [1:0] CLK_INT_PIN   = 2'b01;
   localparam logic [1:0] CLK_INT_FREE  = 2'b10;
   localparam logic [1:0] CLK_SERIAL    = 2'b11;
   localparam logic [1:0] REF_INT_AUTO  = 2'b00;
   localparam logic [1:0] REF_INT_ON    = 2'b10;
   localparam logic [1:0] REF_EXT_DIFF  = 2'b11;
   localparam logic [1:0] SCAN_REPEAT   = 2'b10;
   localparam logic [7:0] SETUP_RESET   = 8'h20;
   localparam logic [7:0] CFG_RESET     = 8'h00;
   // kelvin to celsius in eighths of a degree
   localparam logic [11:0] TEMP_OFFSET  = 12'h889;

endpackage

// File: hw/asc_byte_rx.sv
`timescale 1ns/1ns
module asc_byte_rx (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic       cs_n,
   input  wire logic       sclk_rise,
   input  wire logic       din,
   output logic            byte_valid,
   output logic [7:0]      byte_data
);

   logic [2:0] bit_cnt_ff;
   logic [6:0] shift_ff;

   // count restarts whenever chip select is high
   always_ff @(posedge clk or negedge rst_n) begin // RULE25
      if (!rst_n) begin
         bit_cnt_ff <= 3'h0;
         shift_ff   <= 7'h00;
         byte_valid <= 1'b0;
         byte_data  <= 8'h00;
      end else if (ce) begin
         byte_valid <= 1'b0;
         if (cs_n) begin
            bit_cnt_ff <= 3'h0;
         end else if (sclk_rise) begin // RULE18
            shift_ff   <= {shift_ff[5:0], din};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
               byte_valid <= 1'b1;
               byte_data  <= {shift_ff, din};
            end
         end
      end
   end

endmodule

// File: hw/asc_word_tx.sv
`timescale 1ns/1ns
module asc_word_tx (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        load,
   input  wire logic [15:0] word,
   input  wire logic        sclk_fall,
   input  wire logic        cs_n,
   output logic             dout
);

   logic [14:0] rest_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rest_ff <= 15'h0000;
         dout    <= 1'b0;
      end else if (ce) begin
         if (load) begin
            dout    <= word[15]; // RULE16
            rest_ff <= word[14:0];
         end else if (!cs_n && sclk_fall) begin // RULE19
            dout    <= rest_ff[14];
            rest_ff <= {rest_ff[13:0], 1'b0};
         end
      end
   end

endmodule

// File: verif/asc_host_model.sv
`timescale 1ns/1ns
// ****************************************
// host side of the serial link
// ****************************************
module asc_host_model (
   output logic      cs_n,
   output logic      sclk,
   output logic      din,
   input  wire logic dout
);
   // half period; raised while the serial clock converts
   int half_ns = 40;

   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din  = 1'b1;
   end

   task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         din = tx[15 - i];
         #half_ns sclk = 1'b1;
         rx = {rx[14:0], dout};
         #half_ns sclk = 1'b0;
      end
      #half_ns cs_n = 1'b1;
      // no pull on the data line, so show the inverse once released
      din = ~din;
      #half_ns;
   endtask
endmodule

// File: verif/tb.sv
`timescale 1ns/1ns
module tb;
   // ****************************************
   // signals
   // ****************************************
   logic        clk, rst_n, cs_n, sclk, din, dout, cnv_n;
   logic        res_valid, res_temp, use_sclk, cnv_ain, acq_pin;
   logic        ref_int, ref_on, ref_wake, neg_ref, avg_on, rep_ch;
   logic        scan_start, fifo_clear;
   logic [11:0] res_code, t_hi, t_lo;
   logic [3:0]  res_chan, cr;
   logic [1:0]  clock_mode;
   logic [7:0]  uni, bip, bip_eff, avg_cfg, conv_cfg;
   logic [15:0] rx;
   logic [3:0]  chans [3] = '{4'h0, 4'h8, 4'hE};
   // pairs written bipolar (0F) and not unipolar (03)
   logic [7:0]  bip_exp = 8'h0C;
   int          mismatches, samples_checked, n_scan, n_clr, cycles, n, pb;

   asc_ctrl dut_u (.clk(clk), .rst_n(rst_n), .ce(1'b1), .cs_n_pin(cs_n), .sclk_pin(sclk),
      .din_pin(din), .conversion_start_pin(cnv_n), .result_valid(res_valid),
      .result_code(res_code), .result_chan(res_chan), .result_is_temp(res_temp),
      .temp_high_bias(t_hi), .temp_low_bias(t_lo), .dout(dout), .clock_mode(clock_mode),
      .use_serial_conv_clk(use_sclk), .conversion_start_pin_as_analog_input(cnv_ain),
      .acq_timed_by_pin(acq_pin), .ref_internal(ref_int), .ref_always_on(ref_on),
      .ref_wake_delay(ref_wake), .neg_ref_pin_active(neg_ref),
      .unipolar_pair_config(uni), .bipolar_pair_config(bip), .bipolar_pairs_eff(bip_eff),
      .averaging_on(avg_on), .avg_config(avg_cfg), .conv_config(conv_cfg),
      .repeat_channel(rep_ch), .scan_start(scan_start), .fifo_clear(fifo_clear));

   asc_host_model host_u (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ****************************************
   // pulse counters and hang guard
   // ****************************************
   always @(posedge clk) begin
      cycles++;
      if (scan_start === 1'b1) n_scan++;
      if (fifo_clear === 1'b1) n_clr++;
      if (cycles == 30000) begin
         mismatches++;
         wrap_up();
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic send8(input logic [7:0] b);
      host_u.frame({b, 8'h00}, 8, rx);
      @(posedge clk);
      #1;
   endtask

   task automatic send16(input logic [15:0] w);
      host_u.frame(w, 16, rx);
      @(posedge clk);
      #1;
   endtask

   task automatic read_result(input logic [3:0] ch, input logic tmp, output logic [15:0] w);
      res_chan = ch;
      res_temp = tmp;
      res_valid = 1'b1;
      @(posedge clk);
      #1;
      res_valid = 1'b0;
      host_u.frame(16'h0000, 16, w);
      @(posedge clk);
      #1;
   endtask

   task automatic check_defaults();
      check("clock mode", {14'h0, clock_mode}, 16'h0002);
      check("ref decode", {12'h0, cnv_ain, ref_int, ref_wake, ref_on}, 16'h000E);
      check("pair regs", {uni, bip}, 16'h0000);
      check("avg and conv", {avg_cfg, conv_cfg}, 16'h0000);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rst_n = 1'b0;
      cnv_n = 1'b1;
      res_valid = 1'b0;
      res_temp = 1'b0;
      res_chan = 4'h0;
      res_code = 12'hA5C;
      t_hi = 12'hC00;
      t_lo = 12'h100;
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check_defaults();
      for (int i = 0; i < 16; i++) begin
         cr = i[3:0];
         send8({2'b01, cr, 2'b00});
         // serial clock must slow down while it converts
         host_u.half_ns = (cr[3:2] == 2'b11) ? 112 : 40;
         check("clk", {12'h0, clock_mode, use_sclk, acq_pin},
               {12'h0, cr[3:2], cr[3:2] == 2'b11, cr[3:2] == 2'b01});
         check("cnv pin", {15'h0, cnv_ain}, {15'h0, cr[3]});
         check("ref", {12'h0, ref_int, ref_on, ref_wake, neg_ref},
               {12'h0, ~cr[0], cr[1:0] == 2'b10, cr[1:0] == 2'b00, &cr[1:0]});
      end
      check("pairs untouched", {uni, bip}, 16'h0000);
      send16({8'h62, 8'h03});
      send16({8'h63, 8'h0F});
      check("pair regs", {uni, bip}, 16'h030F);
      check("bipolar eff", {8'h00, bip_eff}, 16'h000C);
      n = n_clr;
      send16({8'h61, 8'h18});
      check("pairs kept", {uni, bip}, 16'h030F);
      check("fifo clear", 16'(n_clr - n), 16'h0001);
      check("clock kept", {14'h0, clock_mode}, 16'h0002);
      send8(8'h30);
      check("avg on", {15'h0, avg_on}, 16'h0001);
      send8(8'h70);
      host_u.half_ns = 112;
      check("avg serial", {7'h0, avg_on, avg_cfg}, 16'h0030);
      n = n_scan;
      send8(8'hC4);
      check("byte start", 16'(n_scan - n), 16'h0001);
      check("repeat", {15'h0, rep_ch}, 16'h0001);
      send8(8'hC6);
      check("no repeat", {15'h0, rep_ch}, 16'h0000);
      check("conv reg", {8'h00, conv_cfg}, 16'h00C6);
      send8(8'h40);
      host_u.half_ns = 40;
      n = n_scan;
      send8(8'hC6);
      check("byte in pin mode", 16'(n_scan - n), 16'h0000);
      cnv_n = 1'b0;
      repeat (5) @(posedge clk);
      #1 cnv_n = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      check("pin start", 16'(n_scan - n), 16'h0001);
      for (int k = 0; k < 3; k++) begin
         pb = 7 - int'(chans[k][3:1]);
         read_result(chans[k], 1'b0, rx);
         check("result", rx, {4'h0, res_code ^ {bip_exp[pb], 11'h0}});
      end
      read_result(4'h0, 1'b1, rx);
      check("temperature", rx, {4'h0, t_hi - t_lo - asc_pkg::TEMP_OFFSET});
      n = n_clr;
      send8(8'h10);
      check_defaults();
      check("fifo on reset", 16'(n_clr - n), 16'h0001);
      wrap_up();
   end
endmodule
